// ### logic/acd_pkg.sv
// package with register map, field layout and shared types of the dividers
`default_nettype none
package acd_pkg;
	// printed register offsets, kept as the register index base
	localparam logic [31:0] PCM_DIV_OFF = 32'h5000_1c40;
	localparam logic [31:0] PCM_FRAC_OFF = 32'h5000_1c42;
	localparam logic [31:0] PDM_DIVIDER_VALUE_OFF = 32'h5000_1c44;
	localparam logic [31:0] RATE_CONVERTER_DIVIDER_OFF = 32'h5000_1c46;
	// word index of each register inside the slave window
	localparam logic [2:0] IDX_PCM_DIV = 3'((PCM_DIV_OFF - PCM_DIV_OFF) >> 1);
	localparam logic [2:0] IDX_PCM_FRAC = 3'((PCM_FRAC_OFF - PCM_DIV_OFF) >> 1);
	localparam logic [2:0] IDX_PDM_DIVIDER_VALUE = 3'((PDM_DIVIDER_VALUE_OFF - PCM_DIV_OFF) >> 1);
	localparam logic [2:0] IDX_RATE_CONVERTER_DIVIDER = 3'((RATE_CONVERTER_DIVIDER_OFF - PCM_DIV_OFF) >> 1);
	localparam logic [2:0] IDX_STATUS = 3'h4;
	localparam int NUM_REGS = 5;
	// writable bits of each register, the rest read as zero
	localparam logic [15:0] PCM_DIV_MASK = 16'h3fff;
	localparam logic [15:0] PCM_FRAC_MASK = 16'hffff;
	localparam logic [15:0] PDM_DIVIDER_VALUE_MASK = 16'h03ff;
	localparam logic [15:0] RATE_CONVERTER_DIVIDER_MASK = 16'h01ff;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// field positions
	localparam int PCM_EN_BIT = 12;
	localparam int PCM_DIV_MSB = 11;
	localparam int PDM_EN_BIT = 8;
	localparam int PDM_MASTER_BIT = 9;
	localparam int PDM_DIVIDER_VALUE_MSB = 7;
	localparam int SRC_EN_BIT = 8;
	localparam int RATE_CONVERTER_DIVIDER_MSB = 7;
	// divider channel numbers
	localparam int CH_PCM = 0;
	localparam int CH_PDM = 1;
	localparam int CH_SRC = 2;
	localparam int NUM_CH = 3;
	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one divider channel configuration
	typedef struct packed {
		logic enable;
		logic [11:0] divider;
		logic [15:0] pattern;
	} acd_div_cfg_s;

	// position of the most significant set bit, zero for an empty pattern
	function automatic logic [3:0] acd_msb_pos(input logic [15:0] pat);
		logic [3:0] pos;
		pos = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (pat[i]) begin
				pos = 4'(i);
			end
		end
		return pos;
	endfunction : acd_msb_pos
endpackage : acd_pkg
`default_nettype wire

// ### logic/acd_divider.sv
// one integer divider channel with optional fractional stretch pattern
`default_nettype none
module acd_divider (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire acd_pkg::acd_div_cfg_s i_cfg,
	output logic o_tick,
	output logic [3:0] o_frac_ptr
);
	logic [12:0] count_reg;
	logic [3:0] ptr_reg;
	logic tick_reg;
	logic [3:0] msb;
	logic extra;
	logic [12:0] period;

	// the fraction adds one input cycle where the current pattern bit is one
	assign msb = acd_pkg::acd_msb_pos(i_cfg.pattern);
	assign extra = i_cfg.pattern[ptr_reg]; // R3 R4
	assign period = (i_cfg.divider == 12'h000) ? 13'h0001 + 13'(extra) :
		13'(i_cfg.divider) + 13'(extra);

	// period counter, held at rest while the channel is disabled
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_cfg.enable) begin
			count_reg <= 13'h0000;
			tick_reg <= 1'b0;
		end else if (count_reg >= period - 13'h0001) begin // end of period, divider plus extra cycle
			count_reg <= 13'h0000;
			tick_reg <= 1'b1;
		end else begin
			count_reg <= count_reg + 13'h0001;
			tick_reg <= 1'b0;
		end
	end

	// pattern pointer walks from the leading one down to bit zero and wraps
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_cfg.enable) begin
			ptr_reg <= msb; // R4
		end else if (count_reg >= period - 13'h0001) begin
			if (ptr_reg == 4'h0 || ptr_reg > msb) begin
				ptr_reg <= msb; // R3
			end else begin
				ptr_reg <= ptr_reg - 4'h1; // R4
			end
		end
	end

	assign o_tick = tick_reg;
	assign o_frac_ptr = ptr_reg;
endmodule : acd_divider
`default_nettype wire

// ### logic/acd_clock_dividers.sv
// audio clock dividers for pcm, pdm and rate converter with axi4-lite slave
//
// Operation
// R1 - The pcm clock runs only while the pcm enable bit 12 is one.
// R2 - Software writes the 12-bit pcm divider before or with the enable.
// R3 - The pattern's leading one sets the denominator, its ones the numerator.
// R4 - The pattern is walked downward one bit per period, a one adding a cycle.
// R5 - The pdm clock runs only while the pdm enable bit 8 is one.
// R6 - Software writes the 8-bit pdm divider before or with the enable.
// R7 - Bit 9 zero makes the pdm side a clock slave, one makes it master.
// R8 - The rate converter clock enable runs only while its bit 8 is one.
// R9 - Software writes the rate converter divider before or with its enable.
`default_nettype none
module acd_clock_dividers (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [31:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [31:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_pcm_clk,
	output logic o_pcm_tick,
	output logic o_pdm_clk,
	output logic o_pdm_clock_master_select,
	output logic o_rate_converter_clk_en
);
	logic [15:0] pcm_clock_divider_reg;
	logic [15:0] pcm_fraction_divider_reg;
	logic [15:0] pdm_clock_divider_reg;
	logic [15:0] rate_converter_clock_divider_reg;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic aw_have_reg, w_have_reg;
	logic [31:0] awaddr_reg, wdata_reg, rdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic pcm_clk_reg, pdm_clk_reg, pcm_tick_reg, src_en_reg;
	logic do_write;
	logic [3:0] aw_dec;
	logic [15:0] wmask;
	acd_pkg::acd_div_cfg_s cfg [acd_pkg::NUM_CH];
	logic [acd_pkg::NUM_CH-1:0] tick;
	logic [3:0] frac_ptr [acd_pkg::NUM_CH];
	logic [15:0] status;

	// address to register index, bit 3 of result flags a hit
	function automatic logic [3:0] reg_decode(input logic [31:0] addr);
		logic [3:0] res;
		res = 4'h0;
		if (addr[1:0] == 2'h0 && addr[31:2] < 30'(acd_pkg::NUM_REGS)) begin
			res = {1'b1, addr[4:2]};
		end
		return res;
	endfunction : reg_decode

	// stored value of a register with wstrb merged in on the low two lanes
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] mask);
		return ((old & ~wmask) | (wdata_reg[15:0] & wmask)) & mask;
	endfunction : merge

	assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	// decoded index of the held write address
	assign aw_dec = reg_decode(awaddr_reg);

	// write address channel, one transfer outstanding
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			awready_reg <= 1'b1;
			aw_have_reg <= 1'b0;
			awaddr_reg <= 32'h0000_0000;
		end else if (i_awvalid && awready_reg) begin
			awready_reg <= 1'b0;
			aw_have_reg <= 1'b1;
			awaddr_reg <= i_awaddr;
		end else if (do_write) begin
			aw_have_reg <= 1'b0;
		end else if (bvalid_reg && i_bready) begin
			awready_reg <= 1'b1;
		end
	end

	// write data channel, taken in either order against the address
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wready_reg <= 1'b1;
			w_have_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end else if (i_wvalid && wready_reg) begin
			wready_reg <= 1'b0;
			w_have_reg <= 1'b1;
			wdata_reg <= i_wdata;
			wstrb_reg <= i_wstrb;
		end else if (do_write) begin
			w_have_reg <= 1'b0;
		end else if (bvalid_reg && i_bready) begin
			wready_reg <= 1'b1;
		end
	end

	// write response, error for an unmapped or read-only word
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= acd_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (aw_dec == {1'b1, acd_pkg::IDX_STATUS} ||
				!aw_dec[3]) ? acd_pkg::RESP_SLVERR : acd_pkg::RESP_OKAY;
		end else if (i_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// divider registers; a single write may carry value and enable together
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pcm_clock_divider_reg <= acd_pkg::REG_RESET;
			pcm_fraction_divider_reg <= acd_pkg::REG_RESET;
			pdm_clock_divider_reg <= acd_pkg::REG_RESET;
			rate_converter_clock_divider_reg <= acd_pkg::REG_RESET;
		end else if (do_write) begin
			case (reg_decode(awaddr_reg))
				{1'b1, acd_pkg::IDX_PCM_DIV}: begin
					pcm_clock_divider_reg <= merge(pcm_clock_divider_reg,
						acd_pkg::PCM_DIV_MASK); // R2
				end
				{1'b1, acd_pkg::IDX_PCM_FRAC}: begin
					pcm_fraction_divider_reg <= merge(pcm_fraction_divider_reg,
						acd_pkg::PCM_FRAC_MASK);
				end
				{1'b1, acd_pkg::IDX_PDM_DIVIDER_VALUE}: begin
					pdm_clock_divider_reg <= merge(pdm_clock_divider_reg,
						acd_pkg::PDM_DIVIDER_VALUE_MASK); // R6
				end
				{1'b1, acd_pkg::IDX_RATE_CONVERTER_DIVIDER}: begin
					rate_converter_clock_divider_reg <= merge(
						rate_converter_clock_divider_reg,
						acd_pkg::RATE_CONVERTER_DIVIDER_MASK); // R9
				end
				default: begin
				end
			endcase
		end
	end

	// running state shown to software
	assign status = {4'h0, frac_ptr[acd_pkg::CH_PCM], 5'h00,
		src_en_reg, pdm_clk_reg, pcm_clk_reg};

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= acd_pkg::RESP_OKAY;
		end else if (i_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= acd_pkg::RESP_OKAY;
			case (reg_decode(i_araddr))
				{1'b1, acd_pkg::IDX_PCM_DIV}:
					rdata_reg <= {16'h0000, pcm_clock_divider_reg};
				{1'b1, acd_pkg::IDX_PCM_FRAC}:
					rdata_reg <= {16'h0000, pcm_fraction_divider_reg};
				{1'b1, acd_pkg::IDX_PDM_DIVIDER_VALUE}:
					rdata_reg <= {16'h0000, pdm_clock_divider_reg};
				{1'b1, acd_pkg::IDX_RATE_CONVERTER_DIVIDER}:
					rdata_reg <= {16'h0000, rate_converter_clock_divider_reg};
				{1'b1, acd_pkg::IDX_STATUS}:
					rdata_reg <= {16'h0000, status};
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= acd_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && i_rready) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	// channel configurations; only the pcm channel has a fraction
	assign cfg[acd_pkg::CH_PCM] = '{
		enable: pcm_clock_divider_reg[acd_pkg::PCM_EN_BIT], // R1
		divider: pcm_clock_divider_reg[acd_pkg::PCM_DIV_MSB:0],
		pattern: pcm_fraction_divider_reg}; // R3
	assign cfg[acd_pkg::CH_PDM] = '{
		enable: pdm_clock_divider_reg[acd_pkg::PDM_EN_BIT] &&
			pdm_clock_divider_reg[acd_pkg::PDM_MASTER_BIT], // R5 R7
		divider: {4'h0, pdm_clock_divider_reg[acd_pkg::PDM_DIVIDER_VALUE_MSB:0]},
		pattern: 16'h0000};
	assign cfg[acd_pkg::CH_SRC] = '{
		enable: rate_converter_clock_divider_reg[acd_pkg::SRC_EN_BIT], // R8
		divider: {4'h0,
			rate_converter_clock_divider_reg[acd_pkg::RATE_CONVERTER_DIVIDER_MSB:0]},
		pattern: 16'h0000};

	// one divider per channel
	for (genvar g = 0; g < acd_pkg::NUM_CH; g++) begin : g_div
		acd_divider u_div (
			.i_mclk(i_mclk),
			.i_rst(i_rst),
			.i_cfg(cfg[g]),
			.o_tick(tick[g]),
			.o_frac_ptr(frac_ptr[g])
		);
	end

	// generated clocks toggle on each tick and rest low when disabled
	always_ff @(posedge i_mclk) begin
		if (i_rst || !cfg[acd_pkg::CH_PCM].enable) begin
			pcm_clk_reg <= 1'b0; // R1
			pcm_tick_reg <= 1'b0;
		end else begin
			pcm_clk_reg <= pcm_clk_reg ^ tick[acd_pkg::CH_PCM];
			pcm_tick_reg <= tick[acd_pkg::CH_PCM];
		end
	end

	// pdm clock is driven only as master; as slave it stays low
	always_ff @(posedge i_mclk) begin
		if (i_rst || !cfg[acd_pkg::CH_PDM].enable) begin
			pdm_clk_reg <= 1'b0; // R5 R7
		end else begin
			pdm_clk_reg <= pdm_clk_reg ^ tick[acd_pkg::CH_PDM];
		end
	end

	// rate converter gets a one-cycle enable per divided period
	always_ff @(posedge i_mclk) begin
		if (i_rst || !cfg[acd_pkg::CH_SRC].enable) begin
			src_en_reg <= 1'b0; // R8
		end else begin
			src_en_reg <= tick[acd_pkg::CH_SRC];
		end
	end

	assign o_awready = awready_reg;
	assign o_wready = wready_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign o_arready = arready_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rdata = rdata_reg;
	assign o_rresp = rresp_reg;
	assign o_pcm_clk = pcm_clk_reg;
	assign o_pcm_tick = pcm_tick_reg;
	assign o_pdm_clk = pdm_clk_reg;
	assign o_pdm_clock_master_select =
		pdm_clock_divider_reg[acd_pkg::PDM_MASTER_BIT]; // R7
	assign o_rate_converter_clk_en = src_en_reg;
endmodule : acd_clock_dividers
`default_nettype wire

// ### testbench/acd_clock_dividers_sva.sv
// checker of bus timing and pdm slave behaviour of the dividers
`default_nettype none
module acd_clock_dividers_chk (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic o_pcm_tick,
	input wire logic o_pdm_clk,
	input wire logic o_pdm_clock_master_select
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// write channel handshakes and response timing
	property p_aw_hold;
		i_awvalid && o_awready |=> !o_awready;
	endproperty
	a_aw_hold: assert property (p_aw_hold) else $error("awready stays high");
	property p_w_hold;
		i_wvalid && o_wready |=> !o_wready;
	endproperty
	a_w_hold: assert property (p_w_hold) else $error("wready stays high");
	property p_b_time;
		i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
	endproperty
	a_b_time: assert property (p_b_time) else $error("write answer late");
	property p_b_stand;
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
	endproperty
	a_b_stand: assert property (p_b_stand) else $error("write answer moved");
	property p_b_done;
		o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write not closed");
	// read channel timing and zero data on an error answer
	property p_r_time;
		i_arvalid && o_arready |=> o_rvalid && !o_arready;
	endproperty
	a_r_time: assert property (p_r_time) else $error("read answer late");
	property p_r_stand;
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read data moved");
	property p_r_err;
		o_rvalid && o_rresp == acd_pkg::RESP_SLVERR |-> o_rdata == '0;
	endproperty
	a_r_err: assert property (p_r_err) else $error("error read not zero");
	// slave mode keeps the internal pdm clock low
	property p_pdm_slave;
		!o_pdm_clock_master_select [*2] |-> !o_pdm_clk;
	endproperty
	a_pdm_slave: assert property (p_pdm_slave)
		else $error("pdm clk in slave");
	c_write: cover property (o_bvalid && i_bready);
	c_read: cover property (o_rvalid && i_rready);
	c_tick: cover property (o_pcm_tick);
endmodule : acd_clock_dividers_chk
bind acd_clock_dividers acd_clock_dividers_chk chk_u (.i_mclk, .i_rst,
	.i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
	.i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
	.i_rready, .o_pcm_tick, .o_pdm_clk, .o_pdm_clock_master_select);
`default_nettype wire

// ### testbench/acd_audio_sink.sv
// model of the audio units that consume the divided clocks
`default_nettype none
module acd_audio_sink (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_pcm_tick,
	input wire logic i_pdm_clk,
	input wire logic i_src_en,
	output logic [15:0] o_gap [3],
	output logic [15:0] o_cnt [3]
);
	logic [15:0] age_reg [3];
	logic pdm_q;
	logic [2:0] ev;
	assign ev = {i_src_en, i_pdm_clk ^ pdm_q, i_pcm_tick};
	// spacing and count of events of each channel
	always_ff @(posedge i_mclk) begin
		pdm_q <= i_pdm_clk;
		for (int c = 0; c < 3; c++) begin
			if (i_rst) begin
				age_reg[c] <= '0;
				o_gap[c] <= '0;
				o_cnt[c] <= '0;
			end else if (ev[c]) begin
				o_gap[c] <= age_reg[c] + 16'h0001;
				o_cnt[c] <= o_cnt[c] + 16'h0001;
				age_reg[c] <= '0;
			end else begin
				age_reg[c] <= age_reg[c] + 16'h0001;
			end
		end
	end
endmodule : acd_audio_sink
`default_nettype wire

// ### testbench/test_audio_clock_dividers.sv
// self-checking bench for the audio clock dividers
`default_nettype none
module test_audio_clock_dividers;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid;
	logic pcm_clk, pcm_tick, pdm_clk, pdm_ms, src_en;
	logic [1:0] bresp, rresp;
	logic [15:0] gap [3];
	logic [15:0] cnt [3];
	logic [15:0] c0;
	// pattern 101 walked downward from bit 2 with divider 3
	logic [31:0] c0_exp [4] = '{32'h0000_0003, 32'h0000_0004,
		32'h0000_0004, 32'h0000_0003};
	int bad_count = 0, check_count = 0, cyc = 0;
	always #50 i_mclk = ~i_mclk;
	acd_clock_dividers dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready), .o_pcm_clk(pcm_clk),
		.o_pcm_tick(pcm_tick), .o_pdm_clk(pdm_clk),
		.o_pdm_clock_master_select(pdm_ms),
		.o_rate_converter_clk_en(src_en));
	acd_audio_sink sink_u (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_pcm_tick(pcm_tick), .i_pdm_clk(pdm_clk), .i_src_en(src_en),
		.o_gap(gap), .o_cnt(cnt));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : compare
	// one axi write, both channels offered together
	task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
		@(posedge i_mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		// late bready lets the response stand for one cycle
		bready <= 1'b1;
		@(posedge i_mclk);
		bready <= 1'b0;
		compare({30'h0, bresp}, {30'h0, er});
	endtask : wr
	// one axi read with expected data and response
	task automatic rd(input logic [31:0] a, d, input logic [1:0] er);
		@(posedge i_mclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		// late rready lets the read data stand for one cycle
		rready <= 1'b1;
		@(posedge i_mclk);
		rready <= 1'b0;
		compare(rdata, d);
		compare({30'h0, rresp}, {30'h0, er});
	endtask : rd
	task automatic next(input int ch);
		c0 = cnt[ch];
		while (cnt[ch] == c0) @(posedge i_mclk);
	endtask : next
	task automatic quiet(input int ch);
		repeat (2) @(posedge i_mclk);
		c0 = cnt[ch];
		repeat (40) @(posedge i_mclk);
		compare({16'h0, cnt[ch] - c0}, 32'h0000_0000);
	endtask : quiet
	// cut a hang short
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run;
		end
	end
	initial begin
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (int a = 0; a < 20; a += 4) rd(a, 32'h0000_0000, 2'h0);
		rd(32'h0000_0014, 32'h0000_0000, 2'h2);
		wr(32'h0000_0010, 32'h0000_0001, 2'h2);
		wr(32'h0000_0008, 32'hffff_ffff, 2'h0);
		rd(32'h0000_0008, 32'h0000_03ff, 2'h0);
		wstrb <= 4'h1;
		wr(32'h0000_0008, 32'h0000_0000, 2'h0);
		rd(32'h0000_0008, 32'h0000_0300, 2'h0);
		wstrb <= 4'hf;
		wr(32'h0000_0008, 32'h0000_0000, 2'h0);
		$display("map test done");
		wr(32'h0000_0004, 32'h0000_0005, 2'h0);
		wr(32'h0000_0000, 32'h0000_1003, 2'h0);
		next(0);
		foreach (c0_exp[i]) begin
			next(0);
			compare({16'h0, gap[0]}, c0_exp[i]);
		end
		wr(32'h0000_0000, 32'h0000_0003, 2'h0);
		quiet(0);
		compare({31'h0, pcm_clk}, 32'h0000_0000);
		$display("pcm test done");
		wr(32'h0000_0008, 32'h0000_0102, 2'h0);
		compare({31'h0, pdm_ms}, 32'h0000_0000);
		quiet(1);
		wr(32'h0000_0008, 32'h0000_0302, 2'h0);
		compare({31'h0, pdm_ms}, 32'h0000_0001);
		next(1);
		next(1);
		compare({16'h0, gap[1]}, 32'h0000_0002);
		wr(32'h0000_0008, 32'h0000_0202, 2'h0);
		quiet(1);
		$display("pdm test done");
		wr(32'h0000_000c, 32'h0000_0105, 2'h0);
		next(2);
		next(2);
		compare({16'h0, gap[2]}, 32'h0000_0005);
		wr(32'h0000_000c, 32'h0000_0005, 2'h0);
		quiet(2);
		$display("src test done");
		complete_run;
	end
endmodule : test_audio_clock_dividers
`default_nettype wire
